//--- src/fdpi_pkg.sv
// Constants for the floppy/IDE drive pin interface
package fdpi_pkg;
  localparam int STEP_LOW_NS = 1000;
  localparam int CLK_NS = 50;
  localparam int STEP_LOW_CYC = (STEP_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam logic RST_SELECT = 1'h0;
  localparam logic RST_THREE_MODE = 1'h0;
  localparam logic RST_PULLUP_DIS = 1'h0;
  localparam int SYNC_W = 6;
  typedef enum logic [1:0] {
    FDPI_ST_IDLE = 2'h0,
    FDPI_ST_LOW = 2'h1,
    FDPI_ST_REC = 2'h3
  } fdpi_step_e;
endpackage : fdpi_pkg

//--- src/fdpi_sync.sv
// Two-flop synchroniser bank for drive status pins
`timescale 1ns/1ps
module fdpi_sync #(
  parameter int W = 6
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // Idle level of all these pins is high
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule : fdpi_sync

//--- src/fdpi_top.sv
// Drive-side pin interface: floppy control, status, IDE/IR pin sharing
`timescale 1ns/1ps
module fdpi_top
  import fdpi_pkg::*;
#(
  parameter int STEP_CYC = STEP_LOW_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ir_or_ide_select,
  input wire logic three_mode_enable,
  input wire logic drive_input_pullup_disable,
  input wire logic core_ide_reset,
  input wire logic core_ide_buf_en,
  input wire logic core_irq_g,
  input wire logic core_irq_h,
  input wire logic hdc_base_one_hit,
  input wire logic hdc_base_two_hit,
  input wire logic core_ir_tx,
  input wire logic core_write_gate,
  input wire logic core_write_bit,
  input wire logic core_step_req,
  input wire logic core_dir_in,
  input wire logic core_side_one,
  input wire logic core_rate_500k,
  input wire logic core_three_mode_rwc,
  input wire logic [1:0] core_motor_on,
  input wire logic [1:0] core_drive_sel,
  input wire logic index_hole_in,
  input wire logic track_zero_in,
  input wire logic write_protect_in,
  input wire logic disk_change_in,
  input wire logic drive_read_data_in,
  input wire logic infrared_rx_in,
  output logic ide_reset_out,
  output logic ide_buffer_enable_out,
  output logic ide_chip_select_one,
  output logic ide_chip_select_zero,
  output logic ide_chip_select_zero_oe,
  output logic drive_write_gate,
  output logic drive_write_gate_oe,
  output logic drive_write_data,
  output logic drive_write_data_oe,
  output logic step_pulse_out,
  output logic step_pulse_out_oe,
  output logic step_direction_out,
  output logic step_direction_out_oe,
  output logic head_side_select,
  output logic head_side_select_oe,
  output logic reduced_write_current,
  output logic reduced_write_current_oe,
  output logic [1:0] motor_on_n,
  output logic [1:0] motor_on_n_oe,
  output logic [1:0] drive_sel_n,
  output logic [1:0] drive_sel_n_oe,
  output logic input_pullup_on,
  output logic index_seen,
  output logic track_zero,
  output logic disk_protected,
  output logic disk_changed,
  output logic read_pulse,
  output logic ir_rx_data,
  output logic step_busy
);
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic ide_reset_r, ide_reset_nxt;
  logic ide_buf_r, ide_buf_nxt;
  logic cs1_r, cs1_nxt;
  logic cs0_r, cs0_nxt;
  logic cs0_oe_r, cs0_oe_nxt;
  logic wg_oe_r, wg_oe_nxt;
  logic wd_oe_r, wd_oe_nxt;
  logic dir_oe_r, dir_oe_nxt;
  logic head_oe_r, head_oe_nxt;
  logic rwc_oe_r, rwc_oe_nxt;
  logic [1:0] mot_oe_r, mot_oe_nxt;
  logic [1:0] sel_oe_r, sel_oe_nxt;
  logic pu_r, pu_nxt;
  logic idx_r, idx_nxt;
  logic trk_r, trk_nxt;
  logic wp_r, wp_nxt;
  logic chg_r, chg_nxt;
  logic rd_prev_r, rd_prev_nxt;
  logic rdp_r, rdp_nxt;
  logic irrx_r, irrx_nxt;
  fdpi_step_e st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic rwc_level;
  logic step_oe_r, step_oe_nxt;
  logic busy_r, busy_nxt;
  logic [15:0] low_len_r, low_len_nxt;

  assign pins_raw = {infrared_rx_in, drive_read_data_in, disk_change_in,
                     write_protect_in, track_zero_in, index_hole_in};

  fdpi_sync #(.W(SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // Shared IDE/IR pins
  always_comb begin
    ide_reset_nxt = ir_or_ide_select ? core_irq_g : ~core_ide_reset;
    ide_buf_nxt = ir_or_ide_select ? core_irq_h : ~core_ide_buf_en;
    // chip select one or IR transmit
    cs1_nxt = ir_or_ide_select ? core_ir_tx : ~hdc_base_two_hit;
    // chip select zero or IR receive
    cs0_nxt = ~hdc_base_one_hit;
    cs0_oe_nxt = ~ir_or_ide_select;
    irrx_nxt = ir_or_ide_select ? pins_s[5] : 1'h1;
  end

  // Open-drain floppy controls: enable pulls low
  always_comb begin
    rwc_level = three_mode_enable ? core_three_mode_rwc : core_rate_500k;
    wg_oe_nxt = core_write_gate;
    wd_oe_nxt = core_write_gate & core_write_bit;
    dir_oe_nxt = core_dir_in;
    head_oe_nxt = core_side_one;
    rwc_oe_nxt = ~rwc_level;
    mot_oe_nxt = core_motor_on;
    sel_oe_nxt = core_drive_sel;
    pu_nxt = ~drive_input_pullup_disable;
  end

  // Status inputs, active low at the pins
  always_comb begin
    idx_nxt = ~pins_s[0];
    trk_nxt = ~pins_s[1];
    wp_nxt = ~pins_s[2];
    chg_nxt = ~pins_s[3];
    // falling edge marks a read pulse
    rd_prev_nxt = pins_s[4];
    rdp_nxt = rd_prev_r & ~pins_s[4];
  end

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      FDPI_ST_IDLE: begin
        if (core_step_req) begin
          st_nxt = FDPI_ST_LOW;
          cnt_nxt = 16'(STEP_CYC - 1);
        end
      end
      FDPI_ST_LOW: begin
        if (cnt_r == 16'h0) begin
          st_nxt = FDPI_ST_REC;
          cnt_nxt = 16'(STEP_CYC - 1);
        end else begin
          cnt_nxt = cnt_r - 16'h1;
        end
      end
      FDPI_ST_REC: begin
        if (cnt_r == 16'h0) begin
          st_nxt = FDPI_ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 16'h1;
        end
      end
      default: begin
        st_nxt = FDPI_ST_IDLE;
      end
    endcase
    step_oe_nxt = (st_nxt == FDPI_ST_LOW);
    busy_nxt = (st_nxt != FDPI_ST_IDLE);
    low_len_nxt = step_oe_r ? low_len_r + 16'h1 : 16'h0;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ide_reset_r <= 1'h0;
      ide_buf_r <= 1'h1;
      cs1_r <= 1'h1;
      cs0_r <= 1'h1;
      cs0_oe_r <= 1'h1;
      wg_oe_r <= 1'h0;
      wd_oe_r <= 1'h0;
      dir_oe_r <= 1'h0;
      head_oe_r <= 1'h0;
      rwc_oe_r <= 1'h0;
      mot_oe_r <= 2'h0;
      sel_oe_r <= 2'h0;
      pu_r <= 1'h1;
      idx_r <= 1'h0;
      trk_r <= 1'h0;
      wp_r <= 1'h0;
      chg_r <= 1'h0;
      rd_prev_r <= 1'h1;
      rdp_r <= 1'h0;
      irrx_r <= 1'h1;
      st_r <= FDPI_ST_IDLE;
      cnt_r <= 16'h0;
      step_oe_r <= 1'h0;
      busy_r <= 1'h0;
      low_len_r <= 16'h0;
    end else begin
      ide_reset_r <= ide_reset_nxt;
      ide_buf_r <= ide_buf_nxt;
      cs1_r <= cs1_nxt;
      cs0_r <= cs0_nxt;
      cs0_oe_r <= cs0_oe_nxt;
      wg_oe_r <= wg_oe_nxt;
      wd_oe_r <= wd_oe_nxt;
      dir_oe_r <= dir_oe_nxt;
      head_oe_r <= head_oe_nxt;
      rwc_oe_r <= rwc_oe_nxt;
      mot_oe_r <= mot_oe_nxt;
      sel_oe_r <= sel_oe_nxt;
      pu_r <= pu_nxt;
      idx_r <= idx_nxt;
      trk_r <= trk_nxt;
      wp_r <= wp_nxt;
      chg_r <= chg_nxt;
      rd_prev_r <= rd_prev_nxt;
      rdp_r <= rdp_nxt;
      irrx_r <= irrx_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      step_oe_r <= step_oe_nxt;
      busy_r <= busy_nxt;
      low_len_r <= low_len_nxt;
    end
  end

  assign ide_reset_out = ide_reset_r;
  assign ide_buffer_enable_out = ide_buf_r;
  assign ide_chip_select_one = cs1_r;
  assign ide_chip_select_zero = cs0_r;
  assign ide_chip_select_zero_oe = cs0_oe_r;
  assign drive_write_gate = 1'h0;
  assign drive_write_gate_oe = wg_oe_r;
  assign drive_write_data = 1'h0;
  assign drive_write_data_oe = wd_oe_r;
  assign step_pulse_out = 1'h0;
  assign step_pulse_out_oe = step_oe_r;
  assign step_direction_out = 1'h0;
  assign step_direction_out_oe = dir_oe_r;
  assign head_side_select = 1'h0;
  assign head_side_select_oe = head_oe_r;
  assign reduced_write_current = 1'h0;
  assign reduced_write_current_oe = rwc_oe_r;
  assign motor_on_n = 2'h0;
  assign motor_on_n_oe = mot_oe_r;
  assign drive_sel_n = 2'h0;
  assign drive_sel_n_oe = sel_oe_r;
  assign input_pullup_on = pu_r;
  assign index_seen = idx_r;
  assign track_zero = trk_r;
  assign disk_protected = wp_r;
  assign disk_changed = chg_r;
  assign read_pulse = rdp_r;
  assign ir_rx_data = irrx_r;
  assign step_busy = busy_r;

  AST_IDE_RESET_MUX: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !ir_or_ide_select |=> ide_reset_out == !$past(core_ide_reset))
    else $error("ide reset pin wrong in IDE mode");
  AST_IRQ_G_MUX: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ir_or_ide_select |=> ide_reset_out == $past(core_irq_g))
    else $error("irq g not on shared pin");
  AST_BUF_MUX: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> ide_buffer_enable_out == ($past(ir_or_ide_select) ?
      $past(core_irq_h) : !$past(core_ide_buf_en)))
    else $error("buffer enable pin wrong");
  AST_CS1_MUX: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> ide_chip_select_one == ($past(ir_or_ide_select) ?
      $past(core_ir_tx) : !$past(hdc_base_two_hit)))
    else $error("chip select one pin wrong");
  AST_CS0_MUX: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> ide_chip_select_zero_oe == !$past(ir_or_ide_select)
      && ide_chip_select_zero == !$past(hdc_base_one_hit))
    else $error("chip select zero pin wrong");
  AST_WRITE_DATA_GATED: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    drive_write_data_oe |-> $past(core_write_gate))
    else $error("write data without gate");
  AST_RWC_RATE: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !three_mode_enable ##1 1'b1 |->
      reduced_write_current_oe == !$past(core_rate_500k))
    else $error("write current rate coding wrong");
  AST_STEP_WIDTH: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $fell(step_pulse_out_oe) |-> low_len_r == 16'(STEP_CYC))
    else $error("step pulse width wrong");
  AST_RESET_RELEASE: assert property (
    @(posedge sys_clk)
    $past(sys_rst) |-> !step_pulse_out_oe && motor_on_n_oe == 2'h0
      && drive_sel_n_oe == 2'h0 && !drive_write_gate_oe)
    else $error("drive outputs not released after reset");
endmodule : fdpi_top

//--- tb/fdpi_drive_model.sv
// Floppy drive model driving the active-low status pins
`timescale 1ns/1ps
module fdpi_drive_model (
  input wire logic [4:0] act,
  output logic index_hole_in,
  output logic track_zero_in,
  output logic write_protect_in,
  output logic disk_change_in,
  output logic drive_read_data_in
);
  assign index_hole_in = ~act[0];
  assign track_zero_in = ~act[1];
  assign write_protect_in = ~act[2];
  assign disk_change_in = ~act[3];
  assign drive_read_data_in = ~act[4];
endmodule : fdpi_drive_model

//--- tb/testbench.sv
// Self-checking bench for the drive pin interface
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module testbench;
  import fdpi_pkg::*;
  localparam int SC = 4;
  logic sys_clk = 1'b0, sys_rst = 1'b1, core_step_req = 1'b0;
  logic [25:0] stim = '0;
  logic [25:0] h [0:3];
  logic ir_or_ide_select, three_mode_enable, drive_input_pullup_disable;
  logic core_ide_reset, core_ide_buf_en, core_irq_g, core_irq_h;
  logic hdc_base_one_hit, hdc_base_two_hit, core_ir_tx, core_write_gate;
  logic core_write_bit, core_dir_in, core_side_one, core_rate_500k;
  logic core_three_mode_rwc, infrared_rx_in;
  logic [1:0] core_motor_on, core_drive_sel, motor_on_n, motor_on_n_oe;
  logic [1:0] drive_sel_n, drive_sel_n_oe;
  logic index_hole_in, track_zero_in, write_protect_in, disk_change_in;
  logic drive_read_data_in, ide_reset_out, ide_buffer_enable_out;
  logic ide_chip_select_one, ide_chip_select_zero, ide_chip_select_zero_oe;
  logic drive_write_gate, drive_write_gate_oe, drive_write_data;
  logic drive_write_data_oe, step_pulse_out, step_pulse_out_oe;
  logic step_direction_out, step_direction_out_oe, head_side_select;
  logic head_side_select_oe, reduced_write_current;
  logic reduced_write_current_oe, input_pullup_on, index_seen, track_zero;
  logic disk_protected, disk_changed, read_pulse, ir_rx_data, step_busy;
  int err_count = 0, n_checks = 0, hi, bsy, rises;
  assign {core_drive_sel, core_motor_on, core_three_mode_rwc,
    core_rate_500k, core_side_one, core_dir_in, core_write_bit,
    core_write_gate, core_ir_tx, hdc_base_two_hit, hdc_base_one_hit,
    core_irq_h, core_irq_g, core_ide_buf_en, core_ide_reset,
    drive_input_pullup_disable, three_mode_enable,
    ir_or_ide_select} = stim[19:0];
  assign infrared_rx_in = stim[25];
  fdpi_drive_model drv (.act(stim[24:20]), .index_hole_in(index_hole_in),
    .track_zero_in(track_zero_in), .write_protect_in(write_protect_in),
    .disk_change_in(disk_change_in),
    .drive_read_data_in(drive_read_data_in));
  fdpi_top #(.STEP_CYC(SC)) dut (.*);
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    h[0] <= stim;
    for (int i = 1; i < 4; i++) h[i] <= h[i-1];
  end
  function automatic logic [13:0] exp_fast(input logic [25:0] s);
    return {s[0] ? s[5] : ~s[3], s[0] ? s[6] : ~s[4],
      s[0] ? s[9] : ~s[8], ~s[0], s[10], s[10] & s[11], s[12], s[13],
      ~(s[1] ? s[15] : s[14]), s[17:16], s[19:18], ~s[2]};
  endfunction : exp_fast
  task automatic check_cycle;
    logic [25:0] s;
    logic [13:0] e;
    s = h[0];
    e = exp_fast(s);
    `CHK(ide_reset_out, e[13])
    `CHK(ide_buffer_enable_out, e[12])
    `CHK(ide_chip_select_one, e[11])
    `CHK(ide_chip_select_zero_oe, e[10])
    if (!s[0]) `CHK(ide_chip_select_zero, ~s[7])
    `CHK(drive_write_gate_oe, e[9])
    `CHK(drive_write_data_oe, e[8])
    `CHK({drive_write_gate, drive_write_data, step_pulse_out,
      step_direction_out, head_side_select, reduced_write_current,
      motor_on_n, drive_sel_n}, 10'h000)
    `CHK(step_direction_out_oe, e[7])
    `CHK(head_side_select_oe, e[6])
    if (s[1]) `CHK(reduced_write_current_oe, e[5])
    else `CHK(reduced_write_current_oe, e[5])
    `CHK(motor_on_n_oe, e[4:3])
    `CHK(drive_sel_n_oe, e[2:1])
    `CHK(input_pullup_on, e[0])
    `CHK({disk_changed, disk_protected, track_zero, index_seen},
      h[2][23:20])
    `CHK(read_pulse, h[2][24] & ~h[3][24])
    if (h[0][0] == h[1][0] && h[1][0] == h[2][0])
      `CHK(ir_rx_data, h[0][0] ? h[2][25] : 1'b1)
  endtask : check_cycle
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial begin
    #(50 * 5000);
    err_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(84735));
    repeat (11) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK({drive_write_gate_oe, drive_write_data_oe, step_pulse_out_oe,
      step_direction_out_oe, head_side_select_oe, reduced_write_current_oe,
      motor_on_n_oe, drive_sel_n_oe, ide_chip_select_zero_oe,
      ide_reset_out, input_pullup_on}, 13'h0005)
    @(posedge sys_clk) sys_rst <= 1'b0;
    $display("test reset done");
    for (int i = 0; i < 400; i++) begin
      @(posedge sys_clk) stim <= (i % 50 == 0) ? '0 : 26'($urandom);
      @(negedge sys_clk);
      if (i > 4) check_cycle();
    end
    $display("test random pins done");
    hi = 0;
    bsy = 0;
    rises = 0;
    for (int i = 0; i < 3 * SC + 4; i++) begin
      @(posedge sys_clk) core_step_req <= (i == 0 || i == 3);
      @(negedge sys_clk);
      rises += int'(step_pulse_out_oe && hi == 0);
      hi += int'(step_pulse_out_oe);
      bsy += int'(step_busy);
      check_cycle();
    end
    `CHK(rises, 1)
    `CHK(hi, SC)
    `CHK(bsy, 2 * SC)
    $display("test step done");
    print_verdict();
  end
endmodule : testbench
